// >>> ued_pkg.sv
// package for the usb device endpoint register block
package ued_pkg;
  localparam logic [7:0] UED_ADDR_DEVADDR  = 8'h10;
  localparam logic [7:0] UED_ADDR_CNT0     = 8'h11;
  localparam logic [7:0] UED_ADDR_MODE0    = 8'h12;
  localparam logic [7:0] UED_ADDR_CNT1     = 8'h13;
  localparam logic [7:0] UED_ADDR_MODE1    = 8'h14;
  localparam logic [7:0] UED_ADDR_CNT2     = 8'h15;
  localparam logic [7:0] UED_ADDR_MODE2    = 8'h16;
  localparam logic [7:0] UED_ADDR_EPIE     = 8'h17;
  localparam logic [7:0] UED_ADDR_PSTAT    = 8'hFF;
  localparam logic [7:0] UED_BUF0_LO       = 8'hE0;
  localparam logic [7:0] UED_BUF0_HI       = 8'hE7;
  localparam logic [7:0] UED_BUF1_BASE     = 8'hE8;
  localparam logic [7:0] UED_BUF2_BASE     = 8'hF0;
  localparam logic [7:0] UED_BUFX_LO       = 8'hF8;
  localparam int         UED_ADDR_EN_BIT   = 7;
  localparam int         UED_SETUP_BIT     = 7;
  localparam int         UED_IN_BIT        = 6;
  localparam int         UED_OUT_BIT       = 5;
  localparam int         UED_ACK_BIT       = 4;
  localparam int         UED_TOGGLE_BIT    = 7;
  localparam int         UED_VALID_BIT     = 6;
  localparam int         UED_BUSRST_BIT    = 5;
  localparam logic [7:0] UED_RESET_VALUE   = 8'h00;
  localparam logic [3:0] UED_MODE_DISABLE  = 4'h0;
  localparam logic [3:0] UED_MODE_NAKALL   = 4'h1;
  localparam logic [3:0] UED_MAX_COUNT     = 4'h8;
  localparam logic [4:0] UED_MAX_RX_LEN    = 5'h0A;
  localparam int         UED_CLK_HZ        = 20_000_000;
  localparam int         UED_SE0_NS        = 8000;
  localparam int         UED_SE0_CYCLES    = (UED_SE0_NS * (UED_CLK_HZ / 1_000_000)) / 1000;
  typedef enum logic [1:0] {
    UED_TOK_SETUP = 2'h0,
    UED_TOK_IN    = 2'h1,
    UED_TOK_OUT   = 2'h2
  } ued_token_type;
  // one transaction report from the serial engine
  typedef struct packed {
    logic          data_start;
    logic          ack_start;
    logic          done;
    logic          acked;
    logic [1:0]    ep;
    ued_token_type token;
    logic [4:0]    rx_len;
    logic          rx_ok;
    logic          rx_toggle;
  } ued_txn_type;
endpackage

// >>> ued_regs.sv
// endpoint registers, buffers and bus reset detect of the usb device engine
`timescale 1ns/100ps
module ued_regs #(
  parameter int SE0_CYCLES = ued_pkg::UED_SE0_CYCLES,
  parameter int BUF_DEPTH  = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // cpu port
  input  wire logic [7:0]        port_addr,
  input  wire logic [7:0]        port_wdata,
  input  wire logic              port_write_op,
  input  wire logic              port_read_op,
  output logic      [7:0]        port_rdata,
  // serial engine side
  input  wire ued_pkg::ued_txn_type serial_engine_txn,
  input  wire logic [1:0]        serial_engine_buf_ep,
  input  wire logic [2:0]        serial_engine_buf_idx,
  input  wire logic [7:0]        serial_engine_buf_wdata,
  input  wire logic              serial_engine_buf_we,
  output logic      [7:0]        serial_engine_buf_rdata,
  input  wire logic              dp_level,
  input  wire logic              dm_level,
  // engine controls
  output logic                   serial_engine_enable,
  output logic      [6:0]        serial_engine_address,
  output logic      [11:0]       serial_engine_modes,
  output logic      [11:0]       serial_engine_counts,
  output logic      [2:0]        serial_engine_toggles,
  output logic                   bus_reset_irq,
  output logic      [2:0]        endpoint_irq
);
  import ued_pkg::*;

  logic [7:0] addr_q;
  logic [7:0] mode_q [3];
  logic [7:0] cnt_q  [3];
  logic [2:0] ie_q;
  logic       busrst_q;
  logic       setup_force_q;
  logic       lock_q;
  logic [7:0] rdata_q;
  logic       brirq_q;
  // one variable per endpoint so each generate branch drives only its own
  logic       epirq_q [3];
  logic [7:0] buf_q [3][BUF_DEPTH];
  logic [7:0] eng_rd_q;
  logic [15:0] se0_cnt_q;

  // decode
  wire        se0       = !dp_level && !dm_level;
  wire        se0_hit   = se0 && (se0_cnt_q == 16'(SE0_CYCLES));
  wire        bus_reset = se0_hit;
  wire        wr_addr   = port_write_op && (port_addr == UED_ADDR_DEVADDR);
  wire        wr_ie     = port_write_op && (port_addr == UED_ADDR_EPIE);
  wire        wr_ps     = port_write_op && (port_addr == UED_ADDR_PSTAT);
  wire        rd_mode0  = port_read_op && (port_addr == UED_ADDR_MODE0);
  wire [1:0]  t_ep      = serial_engine_txn.ep;
  wire        t_done    = serial_engine_txn.done && addr_q[UED_ADDR_EN_BIT];
  wire        t_ack     = t_done && serial_engine_txn.acked;
  wire        rx_valid  = serial_engine_txn.rx_ok &&
                          (serial_engine_txn.rx_len <= UED_MAX_RX_LEN);
  wire [3:0]  cur_mode  = mode_q[t_ep][3:0];
  wire        t_active  = t_done && (cur_mode != UED_MODE_DISABLE);
  wire        t_setup   = serial_engine_txn.token == UED_TOK_SETUP;
  wire        t_in      = serial_engine_txn.token == UED_TOK_IN;
  wire        t_out     = serial_engine_txn.token == UED_TOK_OUT;
  wire        t_rxtok   = t_setup || t_out;
  wire        is_check  = (cur_mode == 4'h2) || cur_mode[3:1] == 3'b111;
  // check: zero length data plus crc, toggle one
  wire        chk_ok    = (serial_engine_txn.rx_len == 5'h02) &&
                          serial_engine_txn.rx_toggle;
  wire        buf_blk   = mode_q[0][UED_SETUP_BIT] &&
                          ((port_addr >= UED_BUF0_LO && port_addr <= UED_BUF0_HI) ||
                           port_addr >= UED_BUFX_LO);
  wire        buf_hit   = port_addr >= UED_BUF0_LO;
  wire [1:0]  buf_ep    = 2'(port_addr[4:3] == 2'b11 ? 2'b00 : port_addr[4:3]);
  wire        in_setup  = setup_force_q ||
                          (serial_engine_txn.data_start && t_ep == 2'd0 &&
                           addr_q[UED_ADDR_EN_BIT]);

  // next mode after a completed transaction
  function automatic logic [3:0] next_mode(input logic [3:0] m, input logic s,
                                           input logic ack);
    logic [3:0] r;
    r = m;
    if (s && ack) begin
      r = UED_MODE_NAKALL;
    end else if (ack && m[3] && m[0]) begin
      r = {m[3:1], 1'b0};
    end
    return r;
  endfunction

  // se0 timer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      se0_cnt_q <= 16'h0000;
    end else if (!se0) begin
      se0_cnt_q <= 16'h0000;
    end else if (!se0_hit) begin
      se0_cnt_q <= se0_cnt_q + 16'h0001;
    end
  end

  // address, enables, bus reset flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      addr_q   <= UED_RESET_VALUE;
      ie_q     <= 3'b000;
      busrst_q <= 1'b0;
      brirq_q  <= 1'b0;
    end else begin
      if (bus_reset) begin
        addr_q <= UED_RESET_VALUE;
      end else if (wr_addr) begin
        addr_q <= port_wdata;
      end
      if (wr_ie) begin
        ie_q <= port_wdata[2:0];
      end
      // set beats a clearing write
      if (se0_hit) begin
        busrst_q <= 1'b1;
      end else if (wr_ps) begin
        busrst_q <= port_wdata[UED_BUSRST_BIT];
      end
      brirq_q <= se0_hit && !busrst_q;
    end
  end

  // control endpoint interlock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      setup_force_q <= 1'b0;
      lock_q        <= 1'b0;
    end else begin
      if (serial_engine_txn.data_start && t_ep == 2'd0 && addr_q[UED_ADDR_EN_BIT]) begin
        setup_force_q <= 1'b1;
      end else if (rd_mode0 && !serial_engine_txn.ack_start) begin
        setup_force_q <= 1'b0;
      end
      // engine update wins over same cycle read
      if (t_active && t_ep == 2'd0) begin
        lock_q <= 1'b1;
      end else if (rd_mode0) begin
        lock_q <= 1'b0;
      end
    end
  end

  // per endpoint mode and count
  for (genvar e = 0; e < 3; e++) begin : g_ep
    wire wr_m  = port_write_op && (port_addr == UED_ADDR_MODE0 + 8'(2 * e));
    wire wr_c  = port_write_op && (port_addr == UED_ADDR_CNT0 + 8'(2 * e));
    wire hit   = t_active && (t_ep == 2'(e));
    wire lockd = (e == 0) && lock_q;
    wire okchk = !(is_check && t_out) || chk_ok;
    wire acc   = serial_engine_txn.acked && okchk;
    wire [7:0] kept = (e == 0) ? 8'hFF : 8'h1F;
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        mode_q[e] <= UED_RESET_VALUE;
        cnt_q[e]  <= UED_RESET_VALUE;
        epirq_q[e] <= 1'b0;
      end else begin
        if (hit) begin
          mode_q[e][3:0] <= next_mode(cur_mode, t_setup, acc);
          if (acc) begin
            mode_q[e][UED_ACK_BIT] <= 1'b1;
          end
          if (e == 0) begin
            mode_q[e][UED_SETUP_BIT] <= mode_q[e][UED_SETUP_BIT] | t_setup;
            mode_q[e][UED_IN_BIT]    <= mode_q[e][UED_IN_BIT] | t_in;
            mode_q[e][UED_OUT_BIT]   <= mode_q[e][UED_OUT_BIT] | t_out;
          end
          if (t_rxtok) begin
            cnt_q[e][UED_VALID_BIT]  <= rx_valid;
            cnt_q[e][UED_TOGGLE_BIT] <= serial_engine_txn.rx_toggle;
            cnt_q[e][3:0] <= 4'(serial_engine_txn.rx_len);
          end
        end else begin
          if (wr_m && !lockd) begin
            mode_q[e] <= port_wdata & kept;
          end
          if (e == 0 && in_setup) begin
            mode_q[e][UED_SETUP_BIT] <= 1'b1;
          end
          if (wr_c && !lockd) begin
            cnt_q[e] <= port_wdata;
          end
        end
        epirq_q[e] <= hit && ie_q[e] && (serial_engine_txn.acked || rx_valid);
      end
    end
  end

  // endpoint buffers
  always_ff @(posedge clk) begin
    if (port_write_op && buf_hit && !buf_blk) begin
      buf_q[buf_ep][port_addr[2:0]] <= port_wdata;
    end
    if (serial_engine_buf_we) begin
      buf_q[serial_engine_buf_ep][serial_engine_buf_idx] <= serial_engine_buf_wdata;
    end
  end

  // read mux; unmapped reads zero
  wire [7:0] rd_mux =
    (port_addr == UED_ADDR_DEVADDR) ? addr_q :
    (port_addr == UED_ADDR_CNT0)    ? cnt_q[0] :
    (port_addr == UED_ADDR_MODE0)   ? mode_q[0] :
    (port_addr == UED_ADDR_CNT1)    ? cnt_q[1] :
    (port_addr == UED_ADDR_MODE1)   ? mode_q[1] :
    (port_addr == UED_ADDR_CNT2)    ? cnt_q[2] :
    (port_addr == UED_ADDR_MODE2)   ? mode_q[2] :
    (port_addr == UED_ADDR_EPIE)    ? {5'b00000, ie_q} :
    (port_addr == UED_ADDR_PSTAT)   ? {2'b00, busrst_q, 5'b00000} :
    buf_hit                         ? buf_q[buf_ep][port_addr[2:0]] :
    8'h00;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_q  <= 8'h00;
      eng_rd_q <= 8'h00;
    end else begin
      if (port_read_op) begin
        rdata_q <= rd_mux;
      end
      eng_rd_q <= buf_q[serial_engine_buf_ep][serial_engine_buf_idx];
    end
  end

  // outputs, all registered
  assign port_rdata              = rdata_q;
  assign serial_engine_buf_rdata = eng_rd_q;
  assign serial_engine_enable    = addr_q[UED_ADDR_EN_BIT];
  assign serial_engine_address   = addr_q[6:0];
  assign serial_engine_modes     = {mode_q[2][3:0], mode_q[1][3:0], mode_q[0][3:0]};
  // counts above eight are the engine's to clamp
  assign serial_engine_counts    = {cnt_q[2][3:0], cnt_q[1][3:0], cnt_q[0][3:0]};
  assign serial_engine_toggles   = {cnt_q[2][7], cnt_q[1][7], cnt_q[0][7]};
  assign bus_reset_irq           = brirq_q;
  assign endpoint_irq            = {epirq_q[2], epirq_q[1], epirq_q[0]};
endmodule

// >>> ued_asserts.sv
// concurrent checks on the endpoint register block ports
`timescale 1ns/100ps
module ued_asserts import ued_pkg::*; #(
  parameter int SE0_CYCLES = 4
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // cpu port
  input wire logic [7:0]  port_addr,
  input wire logic [7:0]  port_wdata,
  input wire logic        port_write_op,
  input wire logic        port_read_op,
  input wire logic [7:0]  port_rdata,
  // engine side
  input wire ued_txn_type serial_engine_txn,
  input wire logic        dp_level,
  input wire logic        dm_level,
  input wire logic        serial_engine_enable,
  input wire logic [6:0]  serial_engine_address,
  input wire logic [11:0] serial_engine_modes,
  input wire logic [11:0] serial_engine_counts,
  input wire logic [2:0]  serial_engine_toggles,
  input wire logic        bus_reset_irq,
  input wire logic [2:0]  endpoint_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic       se0     = !dp_level && !dm_level;
  wire logic [3:0] mode_of = serial_engine_modes[{serial_engine_txn.ep, 2'b00} +: 4];
  sequence ep0_setup_s;
    serial_engine_txn.done && serial_engine_txn.acked && serial_engine_txn.ep == 2'h0
      && serial_engine_txn.token == UED_TOK_SETUP;
  endsequence
  // engine report in the same cycle would win, so leave it out
  sequence wr_s(logic [7:0] a);
    port_write_op && port_addr == a && !serial_engine_txn.done;
  endsequence
  addr_write_a: assert property (wr_s(UED_ADDR_DEVADDR) ##0 !se0 |=>
    {serial_engine_enable, serial_engine_address} == $past(port_wdata))
    else $error("address register did not take the write");
  rst_clear_a: assert property ($fell(sys_rst) |-> !serial_engine_enable
    && serial_engine_modes == 12'h000) else $error("state not clear after reset");
  addr_read_a: assert property (port_read_op && !port_write_op && port_addr == UED_ADDR_DEVADDR
    |=> port_rdata == {$past(serial_engine_enable), $past(serial_engine_address)})
    else $error("address read back wrong");
  setup_nak_a: assert property (ep0_setup_s ##0 serial_engine_enable ##0 (serial_engine_modes[3:0]
    inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hA, 4'hB, 4'hE, 4'hF})
    |=> serial_engine_modes[3:0] == UED_MODE_NAKALL) else $error("setup did not force nak");
  ep1_count_a: assert property (wr_s(UED_ADDR_CNT1) |=> serial_engine_counts[7:4] ==
    $past(port_wdata[3:0]) && serial_engine_toggles[1] == $past(port_wdata[7]))
    else $error("ep1 count or toggle wrong");
  quiet_off_a: assert property (serial_engine_txn.done && (!serial_engine_enable ||
    mode_of == UED_MODE_DISABLE) |=> endpoint_irq == 3'h0) else $error("irq while disabled");
  irq_cause_a: assert property (endpoint_irq != 3'h0 |-> $past(serial_engine_txn.done))
    else $error("endpoint irq without a transaction");
  busrst_a: assert property (bus_reset_irq |-> $past(se0, SE0_CYCLES) &&
    !serial_engine_enable && serial_engine_address == 7'h00) else $error("bad bus reset");
endmodule
bind ued_regs ued_asserts #(.SE0_CYCLES(SE0_CYCLES)) u_asserts (.clk(clk), .sys_rst(sys_rst),
  .port_addr(port_addr), .port_wdata(port_wdata), .port_write_op(port_write_op),
  .port_read_op(port_read_op), .port_rdata(port_rdata), .serial_engine_txn(serial_engine_txn),
  .dp_level(dp_level), .dm_level(dm_level), .serial_engine_enable(serial_engine_enable),
  .serial_engine_address(serial_engine_address), .serial_engine_modes(serial_engine_modes),
  .serial_engine_counts(serial_engine_counts), .serial_engine_toggles(serial_engine_toggles),
  .bus_reset_irq(bus_reset_irq), .endpoint_irq(endpoint_irq));

// >>> ued_host_model.sv
// host side stand-in: transaction reports and line levels
`timescale 1ns/100ps
module ued_host_model import ued_pkg::*; (
  // clock
  input  wire logic   clk,
  // reports and lines
  output ued_txn_type txn,
  output logic        dp_level,
  output logic        dm_level
);
  initial begin
    txn      = '0;
    dp_level = 1'b0;
    dm_level = 1'b1;
  end
  // setup shows its data phase, then ack start, then the closing report
  task automatic send(input logic [1:0] ep, input ued_token_type tok, input logic [4:0] len);
    @(posedge clk);
    txn.data_start <= tok == UED_TOK_SETUP;
    @(posedge clk);
    txn.data_start <= 1'b0;
    txn.ack_start  <= 1'b1;
    @(posedge clk);
    txn.ack_start <= 1'b0;
    txn.done      <= 1'b1;
    txn.acked     <= 1'b1;
    txn.ep        <= ep;
    txn.token     <= tok;
    txn.rx_len    <= len;
    txn.rx_ok     <= len <= UED_MAX_RX_LEN;
    txn.rx_toggle <= 1'b1;
    @(posedge clk);
    txn <= '0;
  endtask
  // both lines low, then back to idle
  task automatic se0(input int n);
    @(posedge clk);
    dm_level <= 1'b0;
    repeat (n) @(posedge clk);
    dm_level <= 1'b1;
  endtask
endmodule

// >>> ued_regs_tb_top.sv
// self-checking bench for the endpoint register block
`timescale 1ns/100ps
module ued_regs_tb_top;
  import ued_pkg::*;
  localparam int SE0 = 4;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  port_addr = 8'h00;
  logic [7:0]  port_wdata = 8'h00;
  logic        port_write_op = 1'b0;
  logic        port_read_op = 1'b0;
  logic [7:0]  port_rdata;
  ued_txn_type txn;
  logic        dp_level, dm_level, bus_reset_irq, rd_seen = 1'b0;
  logic [2:0]  endpoint_irq;
  logic [1:0]  eng_ep = 2'h0;
  logic [2:0]  eng_idx = 3'h0;
  logic [7:0]  eng_wd = 8'h00;
  logic        eng_we = 1'b0;
  logic [7:0]  eng_rd;
  logic [15:0] rd_q[$], e16;
  logic [3:0]  irq_q[$];
  logic [7:0]  v, ra[5] = '{UED_ADDR_DEVADDR, UED_ADDR_MODE0, UED_ADDR_MODE1, UED_ADDR_MODE2,
    UED_ADDR_EPIE};
  int          errors = 0, n_checks = 0;
  integer      seed = 32'h33a5;
  always #25 clk = ~clk;
  ued_regs #(.SE0_CYCLES(SE0)) DUT (.clk(clk), .sys_rst(sys_rst), .port_addr(port_addr),
    .port_wdata(port_wdata), .port_write_op(port_write_op), .port_read_op(port_read_op),
    .port_rdata(port_rdata), .serial_engine_txn(txn), .serial_engine_buf_ep(eng_ep),
    .serial_engine_buf_idx(eng_idx), .serial_engine_buf_wdata(eng_wd),
    .serial_engine_buf_we(eng_we),
    .serial_engine_buf_rdata(eng_rd), .dp_level(dp_level), .dm_level(dm_level),
    .serial_engine_enable(), .serial_engine_address(), .serial_engine_modes(),
    .serial_engine_counts(), .serial_engine_toggles(), .bus_reset_irq(bus_reset_irq),
    .endpoint_irq(endpoint_irq));
  ued_host_model host (.clk(clk), .txn(txn), .dp_level(dp_level), .dm_level(dm_level));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    port_write_op <= 1'b1;
    port_addr     <= a;
    port_wdata    <= d;
    @(posedge clk);
    port_write_op <= 1'b0;
  endtask
  // m masks bits whose read value is left open
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    port_read_op <= 1'b1;
    port_addr    <= a;
    rd_q.push_back({m, e & m});
    @(posedge clk);
    port_read_op <= 1'b0;
  endtask
  // an irq with no note pops an unknown and so fails
  always @(posedge clk) begin
    if (rd_seen) begin
      e16 = rd_q.pop_front();
      cmp(port_rdata & e16[15:8], e16[7:0]);
    end
    rd_seen <= port_read_op;
    if (bus_reset_irq !== 1'b0 || endpoint_irq !== 3'h0) begin
      cmp({4'h0, bus_reset_irq, endpoint_irq}, {4'h0, irq_q.pop_front()});
    end
  end
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100_000;
    errors++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], 8'h00, 8'hFF);
    $display("reset values done");
    wr(UED_ADDR_MODE0, 8'h02);
    wr(UED_BUF0_LO, 8'h11);
    host.send(2'h0, UED_TOK_SETUP, 5'h0A);
    rd(UED_ADDR_MODE0, 8'h02, 8'hFF);
    v = {1'b1, 7'($random(seed)) | 7'h01};
    wr(UED_ADDR_DEVADDR, v);
    rd(UED_ADDR_DEVADDR, v, 8'hFF);
    $display("address enable done");
    host.send(2'h0, UED_TOK_SETUP, 5'h0A);
    wr(UED_BUF0_LO, 8'h5A);
    wr(UED_BUF1_BASE, 8'h3C);
    wr(UED_ADDR_MODE0, 8'h00);
    rd(UED_ADDR_MODE0, 8'h91, 8'hFF);
    rd(UED_BUF0_LO, 8'h11, 8'hFF);
    rd(UED_BUF1_BASE, 8'h3C, 8'hFF);
    wr(UED_ADDR_MODE0, 8'h02);
    rd(UED_ADDR_MODE0, 8'h02, 8'hFF);
    wr(UED_BUF0_LO, 8'h5A);
    rd(UED_BUF0_LO, 8'h5A, 8'hFF);
    $display("setup interlock done");
    wr(UED_ADDR_EPIE, 8'h02);
    wr(UED_ADDR_MODE1, 8'h09);
    irq_q.push_back(4'h2);
    host.send(2'h1, UED_TOK_OUT, 5'h06);
    rd(UED_ADDR_MODE1, 8'h18, 8'h1F);
    rd(UED_ADDR_CNT1, 8'h40, 8'h40);
    wr(UED_ADDR_EPIE, 8'h04);
    wr(UED_ADDR_MODE1, 8'h09);
    host.send(2'h1, UED_TOK_OUT, 5'h06);
    host.send(2'h2, UED_TOK_OUT, 5'h06);
    $display("endpoint irq done");
    repeat (4) begin
      v = {1'($random(seed)), 3'h0, 4'({$random(seed)} % 9)};
      wr(UED_ADDR_CNT1, v);
      rd(UED_ADDR_CNT1, v, 8'hFF);
    end
    $display("count toggle done");
    @(posedge clk);
    eng_ep  <= 2'h1;
    eng_idx <= 3'h2;
    eng_wd  <= 8'hC3;
    eng_we  <= 1'b1;
    @(posedge clk);
    eng_we  <= 1'b0;
    rd(UED_BUF1_BASE + 8'h02, 8'hC3, 8'hFF);
    @(posedge clk);
    eng_ep  <= 2'h0;
    eng_idx <= 3'h0;
    repeat (2) @(posedge clk);
    #1 cmp(eng_rd, 8'h5A);
    $display("engine buffer done");
    irq_q.push_back(4'h8);
    host.se0(SE0 + 6);
    rd(UED_ADDR_DEVADDR, 8'h00, 8'hFF);
    rd(UED_ADDR_PSTAT, 8'h20, 8'h20);
    $display("bus reset done");
    print_verdict;
  end
endmodule
